// File: logic/lpe_ctrl.sv
// Register bank and sequencing for three LED program engines
`timescale 1ns/100ps
// Overview of operation
// - Chip enable set runs a start-up sequence, then normal operation.
// - Chip enable clear is standby; exec bits and counters refuse writes.
// - Hold lets the current instruction finish, counter accessible only in hold.
// - Step runs one instruction, bumps counter, returns field to hold.
// - Free run executes continuously from the current counter.
// - Execute once runs one instruction, counter kept, field back to hold.
// - Enable register holds three two-bit exec fields at 5:4, 3:2, 1:0.
// - Each engine counter is its own register at 37h, 38h, 39h.
// - Program memory writes pass only in load mode with busy clear.
// - Any engine loading holds all engines and freezes PWM.
// - Entering load mode clears that engine's counter.
// - Load mode is entered from disabled only, never from run.
// - Counter wraps to zero past its upper limit.
// - Halt aborts the instruction immediately and stops the engine.
// - Mode register fields at 5:4, 3:2 and 1:0, codes disabled/load/run/halt.
// - Run mode executes as the exec field selects.
// - Read-only output maps per engine, reset to zero.
// - Each engine can be disabled on its own.
// - Engine 1 output nine map bit is bit 0 of register 70h.
module lpe_ctrl
    import lpe_pkg::*;
#(
    parameter int INIT_CYC = LOAD_INIT_CYC,
    parameter int TICK_DIV = INSTR_DIV,
    parameter int START_CYC = STARTUP_CYC
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [MAP_W-1:0] i_eng1_map,
    input wire logic [MAP_W-1:0] i_eng2_map,
    input wire logic [MAP_W-1:0] i_eng3_map,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_prog_mem_wr,
    output logic o_normal_mode,
    output logic o_pwm_freeze,
    output logic [2:0] o_engine_busy,
    output logic [2:0] o_engine_running,
    output logic [PC_W-1:0] o_pc1,
    output logic [PC_W-1:0] o_pc2,
    output logic [PC_W-1:0] o_pc3,
    output logic [7:0] o_pump_gain_ctrl
);
    // ****************************************************************
    // Field helpers
    // ****************************************************************
    function automatic int field_lsb(input int eng);
        field_lsb = (eng == 0) ? ENG_FIELD_LSB1 : (eng == 1) ? ENG_FIELD_LSB2 : ENG_FIELD_LSB3;
    endfunction

    function automatic logic [7:0] pad_pc(input logic [PC_W-1:0] pc);
        pad_pc = {1'b0, pc};
    endfunction

    // Register state and engine hand-offs
    logic chip_en_r;
    logic [5:0] exec_r;
    logic [5:0] exec_nxt;
    logic [5:0] mode_r;
    logic [5:0] mode_nxt;
    logic [7:0] gain_r;
    logic [MAP_W-1:0] map1_r;
    logic [MAP_W-1:0] map2_r;
    logic [MAP_W-1:0] map3_r;
    logic [15:0] start_cnt_r;
    logic normal_r;
    logic [31:0] div_cnt_r;
    logic tick_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic prog_wr_r;
    logic [2:0] exec_clr;
    logic [2:0] running;
    logic [2:0] busy;
    logic [PC_W-1:0] pc [3];
    logic [2:0] pc_wr;
    logic [2:0] in_load;
    logic [2:0] in_hold;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire wr_en = i_reg_wr && (i_reg_addr == ADDR_ENABLE);
    wire wr_mode = i_reg_wr && (i_reg_addr == ADDR_MODE);
    wire wr_gain = i_reg_wr && (i_reg_addr == ADDR_GAIN);
    wire wr_mem = i_reg_wr && (i_reg_addr >= ADDR_MEM_LO) && (i_reg_addr <= ADDR_MEM_HI);
    wire any_load = |in_load;
    wire engines_active = normal_r && !any_load;
    wire mem_ok = any_load && !(|busy);

    // Per-engine field handling
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_eng
            localparam int LSB = field_lsb(g);
            wire [1:0] cur_mode = mode_r[LSB +: FIELD_W];
            wire [1:0] new_mode = i_reg_wdata[LSB +: FIELD_W];
            wire [1:0] cur_exec = exec_r[LSB +: FIELD_W];
            wire load_bad = (new_mode == MODE_LOAD) && (cur_mode != MODE_DIS)
                && (cur_mode != MODE_LOAD);
            assign in_load[g] = (cur_mode == MODE_LOAD);
            assign in_hold[g] = (cur_exec == EXEC_HOLD);
            assign pc_wr[g] = i_reg_wr && (i_reg_addr == ADDR_PC1 + 8'(g)) && chip_en_r
                && in_hold[g] && !running[g];

            // Software write takes priority over a completion clear
            always_comb
            begin
                exec_nxt[LSB +: FIELD_W] = cur_exec;
                mode_nxt[LSB +: FIELD_W] = cur_mode;
                if (wr_en && chip_en_r)
                begin
                    exec_nxt[LSB +: FIELD_W] = i_reg_wdata[LSB +: FIELD_W];
                end
                else if (exec_clr[g])
                begin
                    exec_nxt[LSB +: FIELD_W] = EXEC_HOLD;
                end
                if (wr_mode && !load_bad)
                begin
                    mode_nxt[LSB +: FIELD_W] = new_mode;
                end
            end

            lpe_engine #(
                .INIT_CYC(INIT_CYC)
            ) u_engine (
                .i_clk(i_clk),
                .i_arst_n(i_arst_n),
                .i_mode(cur_mode),
                .i_exec(cur_exec),
                .i_active(engines_active),
                .i_tick(tick_r),
                .i_pc_wr(pc_wr[g]),
                .i_pc_wdata(i_reg_wdata[PC_W-1:0]),
                .o_pc(pc[g]),
                .o_exec_clr(exec_clr[g]),
                .o_running(running[g]),
                .o_busy(busy[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            chip_en_r <= 1'b0;
            exec_r <= RST_BYTE[5:0];
            mode_r <= RST_BYTE[5:0];
            gain_r <= RST_BYTE;
        end
        else
        begin
            if (wr_en)
            begin
                chip_en_r <= i_reg_wdata[CHIP_EN_BIT];
            end
            exec_r <= exec_nxt;
            mode_r <= mode_nxt;
            if (wr_gain)
            begin
                gain_r <= i_reg_wdata;
            end
        end
    end

    // Start-up sequence; dropping enable returns to standby at once
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            start_cnt_r <= 16'h0;
            normal_r <= 1'b0;
        end
        else if (!chip_en_r)
        begin
            start_cnt_r <= 16'h0;
            normal_r <= 1'b0;
        end
        else if (start_cnt_r != 16'(START_CYC))
        begin
            start_cnt_r <= start_cnt_r + 16'h1;
        end
        else
        begin
            normal_r <= 1'b1;
        end
    end

    // Instruction rate divider; one instruction takes one tick
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end
        else if (div_cnt_r == 32'(TICK_DIV - 1))
        begin
            div_cnt_r <= 32'h0;
            tick_r <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // Output maps mirrored from the execution unit, cleared by reset
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            map1_r <= MAP_W'(RST_BYTE);
            map2_r <= MAP_W'(RST_BYTE);
            map3_r <= MAP_W'(RST_BYTE);
        end
        else
        begin
            map1_r <= i_eng1_map;
            map2_r <= i_eng2_map;
            map3_r <= i_eng3_map;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped and write-only addresses read as zero
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = RST_BYTE;
        unique case (i_reg_addr)
            ADDR_ENABLE: rd_mux = {1'b0, chip_en_r, exec_r};
            ADDR_MODE: rd_mux = {2'b00, mode_r};
            ADDR_PC1: rd_mux = in_hold[0] ? pad_pc(pc[0]) : RST_BYTE;
            ADDR_PC2: rd_mux = in_hold[1] ? pad_pc(pc[1]) : RST_BYTE;
            ADDR_PC3: rd_mux = in_hold[2] ? pad_pc(pc[2]) : RST_BYTE;
            ADDR_MAP1_HI: rd_mux = {7'h00, map1_r[MAP_W-1]};
            ADDR_MAP1_LO: rd_mux = map1_r[7:0];
            ADDR_MAP2_HI: rd_mux = {7'h00, map2_r[MAP_W-1]};
            ADDR_MAP2_LO: rd_mux = map2_r[7:0];
            ADDR_MAP3_HI: rd_mux = {7'h00, map3_r[MAP_W-1]};
            ADDR_MAP3_LO: rd_mux = map3_r[7:0];
            ADDR_GAIN: rd_mux = gain_r;
            default: rd_mux = RST_BYTE;
        endcase
    end

    // Read data and memory write strobe are registered
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_r <= RST_BYTE;
            rvalid_r <= 1'b0;
            prog_wr_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= i_reg_rd;
            if (i_reg_rd)
            begin
                rdata_r <= rd_mux;
            end
            prog_wr_r <= wr_mem && mem_ok;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Straight from flops or decode; nothing here adds a cycle
    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_prog_mem_wr = prog_wr_r;
    assign o_normal_mode = normal_r;
    assign o_pwm_freeze = any_load;
    assign o_engine_busy = busy;
    assign o_engine_running = running;
    assign o_pc1 = pc[0];
    assign o_pc2 = pc[1];
    assign o_pc3 = pc[2];
    assign o_pump_gain_ctrl = gain_r;
endmodule // lpe_ctrl

// File: logic/lpe_pkg.sv
// Shared constants for the LED program engine control block
package lpe_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_PC1 = 8'h37;
    localparam logic [7:0] ADDR_PC2 = 8'h38;
    localparam logic [7:0] ADDR_PC3 = 8'h39;
    localparam logic [7:0] ADDR_MEM_LO = 8'h50;
    localparam logic [7:0] ADDR_MEM_HI = 8'h6f;
    localparam logic [7:0] ADDR_MAP1_HI = 8'h70;
    localparam logic [7:0] ADDR_MAP1_LO = 8'h71;
    localparam logic [7:0] ADDR_MAP2_HI = 8'h72;
    localparam logic [7:0] ADDR_MAP2_LO = 8'h73;
    localparam logic [7:0] ADDR_MAP3_HI = 8'h74;
    localparam logic [7:0] ADDR_MAP3_LO = 8'h75;
    localparam logic [7:0] ADDR_GAIN = 8'h76;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int CHIP_EN_BIT = 6;
    localparam int FIELD_W = 2;
    localparam int ENG_FIELD_LSB1 = 4;
    localparam int ENG_FIELD_LSB2 = 2;
    localparam int ENG_FIELD_LSB3 = 0;
    localparam int PC_W = 7;
    localparam int MAP_W = 9;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_ZERO = 7'h00;
    localparam logic [PC_W-1:0] PC_ONE = 7'h01;
    localparam logic [PC_W-1:0] PC_LIMIT = 7'h5f;

    // ****************************************************************
    // Codes
    // ****************************************************************
    typedef enum logic [1:0] {EXEC_HOLD = 2'h0, EXEC_STEP = 2'h1, EXEC_FREE = 2'h2,
        EXEC_ONCE = 2'h3} lpe_exec_t;
    typedef enum logic [1:0] {MODE_DIS = 2'h0, MODE_LOAD = 2'h1, MODE_RUN = 2'h2,
        MODE_HALT = 2'h3} lpe_mode_t;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int LOAD_INIT_US = 1000;
    localparam int LOAD_INIT_CYC = LOAD_INIT_US * CLK_MHZ;
    localparam int STARTUP_CYC = 16;
    localparam int INSTR_DIV = 3058;
endpackage

// File: logic/lpe_engine.sv
// One program execution engine: sequencing, program counter and load init
`timescale 1ns/100ps
module lpe_engine
    import lpe_pkg::*;
#(
    parameter int INIT_CYC = LOAD_INIT_CYC
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [1:0] i_mode,
    input wire logic [1:0] i_exec,
    input wire logic i_active,
    input wire logic i_tick,
    input wire logic i_pc_wr,
    input wire logic [PC_W-1:0] i_pc_wdata,
    output logic [PC_W-1:0] o_pc,
    output logic o_exec_clr,
    output logic o_running,
    output logic o_busy
);
    typedef enum logic {ENG_IDLE, ENG_EXEC} lpe_eng_t;

    lpe_eng_t state_r;
    lpe_eng_t state_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [1:0] mode_prev_r;
    logic [31:0] init_cnt_r;
    logic [1:0] code_r;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire load_enter = (i_mode == MODE_LOAD) && (mode_prev_r != MODE_LOAD);
    wire run_ok = (i_mode == MODE_RUN) && i_active;
    wire abort = (i_mode != MODE_RUN);
    wire start = (state_r == ENG_IDLE) && run_ok && (i_exec != EXEC_HOLD);
    wire done = (state_r == ENG_EXEC) && run_ok && i_tick;
    wire [PC_W-1:0] pc_inc = (pc_r == PC_LIMIT) ? PC_ZERO : pc_r + PC_ONE;
    wire advance = (code_r == EXEC_STEP) || (code_r == EXEC_FREE);

    // Next state: halt or disable drops the instruction at once
    always_comb
    begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        o_exec_clr = 1'b0;
        if (abort)
        begin
            state_nxt = ENG_IDLE;
        end
        else if (start)
        begin
            state_nxt = ENG_EXEC;
        end
        else if (done)
        begin
            state_nxt = ENG_IDLE;
            if (advance)
            begin
                pc_nxt = pc_inc;
            end
            o_exec_clr = (code_r == EXEC_STEP) || (code_r == EXEC_ONCE);
        end
        if (load_enter)
        begin
            pc_nxt = PC_ZERO;
        end
        else if (i_pc_wr)
        begin
            pc_nxt = i_pc_wdata;
        end
    end

    // State, counter and captured exec code
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r <= ENG_IDLE;
            pc_r <= PC_ZERO;
            mode_prev_r <= MODE_DIS;
            code_r <= EXEC_HOLD;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            mode_prev_r <= i_mode;
            if (start)
            begin
                code_r <= i_exec;
            end
        end
    end

    // Load-mode initialisation time, memory refused meanwhile
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            init_cnt_r <= 32'h0;
        end
        else if (load_enter)
        begin
            init_cnt_r <= 32'(INIT_CYC);
        end
        else if (i_mode != MODE_LOAD)
        begin
            init_cnt_r <= 32'h0; // Leaving load early must not leave busy standing
        end
        else if (init_cnt_r != 32'h0)
        begin
            init_cnt_r <= init_cnt_r - 32'h1;
        end
    end

    assign o_pc = pc_r;
    assign o_running = (state_r == ENG_EXEC);
    assign o_busy = (init_cnt_r != 32'h0);
endmodule // lpe_engine

// File: test/lpe_ctrl_sva.sv
// Assertion checker for the LED program engine control block
`timescale 1ns/100ps
module lpe_ctrl_sva
    import lpe_pkg::*;
#(
    parameter int INIT_CYC = LOAD_INIT_CYC,
    parameter int TICK_DIV = INSTR_DIV,
    parameter int START_CYC = STARTUP_CYC
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [MAP_W-1:0] i_eng1_map,
    input wire logic [MAP_W-1:0] i_eng2_map,
    input wire logic [MAP_W-1:0] i_eng3_map,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_prog_mem_wr,
    input wire logic o_normal_mode,
    input wire logic o_pwm_freeze,
    input wire logic [2:0] o_engine_busy,
    input wire logic [2:0] o_engine_running,
    input wire logic [PC_W-1:0] o_pc1,
    input wire logic [PC_W-1:0] o_pc2,
    input wire logic [PC_W-1:0] o_pc3,
    input wire logic [7:0] o_pump_gain_ctrl
);
    localparam int ST_MAX = START_CYC + 2;
    // Write decodes used by several properties
    wire logic wr_en = i_reg_wr && (i_reg_addr == ADDR_ENABLE);
    wire logic wr_mode = i_reg_wr && (i_reg_addr == ADDR_MODE);
    wire logic wr_mem = i_reg_wr && (i_reg_addr >= ADDR_MEM_LO) && (i_reg_addr <= ADDR_MEM_HI);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_RVALID: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read gave no valid strobe");
    AST_STARTUP: assert property (wr_en && i_reg_wdata[CHIP_EN_BIT] && !o_normal_mode
        |-> ##[1:ST_MAX] o_normal_mode)
        else $error("start-up did not finish in time");
    AST_STANDBY: assert property (wr_en && !i_reg_wdata[CHIP_EN_BIT] |-> ##2 !o_normal_mode)
        else $error("standby did not drop normal mode");
    AST_MEM_GATE: assert property (o_prog_mem_wr
        |-> $past(wr_mem && o_pwm_freeze && (o_engine_busy == 3'h0)))
        else $error("memory write passed outside load");
    AST_FREEZE_BUSY: assert property (|o_engine_busy |-> o_pwm_freeze)
        else $error("busy without freeze");
    AST_HOLD_ALL: assert property (o_pwm_freeze && $past(o_pwm_freeze) && !$past(i_reg_wr)
        && !$past(i_reg_wr, 2) |-> $stable(o_pc1) && $stable(o_pc2) && $stable(o_pc3))
        else $error("counter moved while loading");
    AST_PC_WRAP: assert property ($past(o_pc1) == PC_LIMIT && o_pc1 != PC_LIMIT
        && !$past(i_reg_wr) |-> o_pc1 == PC_ZERO)
        else $error("counter did not wrap to zero");
    AST_PC_MOVE: assert property ($changed(o_pc1) && !$past(i_reg_wr)
        |-> o_pc1 == $past(o_pc1) + PC_ONE || o_pc1 == PC_ZERO)
        else $error("counter jumped");
    AST_LOAD_CLR: assert property ($rose(o_engine_busy[0]) |-> ##[0:1] o_pc1 == PC_ZERO)
        else $error("load entry kept the counter");
    AST_HALT_STOP: assert property (wr_mode && (i_reg_wdata[5:4] == MODE_HALT
        || i_reg_wdata[5:4] == MODE_DIS) |-> ##2 !o_engine_running[0])
        else $error("engine kept running after halt");

    // Main scenarios reached
    COV_LOAD: cover property ($rose(o_engine_busy[0]));
    COV_MEM: cover property (o_prog_mem_wr);
    COV_WRAP: cover property ($past(o_pc1) == PC_LIMIT && o_pc1 == PC_ZERO);
endmodule // lpe_ctrl_sva

bind lpe_ctrl lpe_ctrl_sva #(.INIT_CYC(INIT_CYC), .TICK_DIV(TICK_DIV), .START_CYC(START_CYC))
    u_sva (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_eng1_map(i_eng1_map),
    .i_eng2_map(i_eng2_map), .i_eng3_map(i_eng3_map), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_prog_mem_wr(o_prog_mem_wr), .o_normal_mode(o_normal_mode),
    .o_pwm_freeze(o_pwm_freeze), .o_engine_busy(o_engine_busy),
    .o_engine_running(o_engine_running), .o_pc1(o_pc1), .o_pc2(o_pc2), .o_pc3(o_pc3),
    .o_pump_gain_ctrl(o_pump_gain_ctrl));

// File: test/lpe_host_model.sv
// Host model: byte register master facing the engine control block
`timescale 1ns/100ps
module lpe_host_model
    import lpe_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    input wire logic [2:0] i_busy,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // Released lines show the inverse so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask

    // Waits out the init; an early write would simply be dropped
    task automatic load(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (i_busy !== 3'h0 && n < 1000)
        begin
            @(posedge i_clk);
            n++;
        end
        wr(a, d);
    endtask
endmodule // lpe_host_model

// File: test/led_program_engine_control_tb.sv
// Self-checking bench for the LED program engine control block
`timescale 1ns/100ps
module led_program_engine_control_tb;
    import lpe_pkg::*;
    localparam int TDIV = 4;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic reg_wr, reg_rd, rvalid, mem_wr, normal, freeze;
    logic [7:0] addr, wdata, rdata, gain, rv, pg;
    logic [MAP_W-1:0] mp [3] = '{9'h000, 9'h000, 9'h000};
    logic [2:0] busy, run;
    logic [PC_W-1:0] pc1, pc2, pc3, pc, p;
    logic [1:0] codes [3] = '{MODE_DIS, MODE_RUN, MODE_HALT};
    logic [7:0] ra [10] = '{8'h00, 8'h01, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h40};
    int errors = 0;
    int checks = 0;
    int mem_n = 0;

    always #5 i_clk = ~i_clk;

    lpe_ctrl #(.INIT_CYC(20), .TICK_DIV(TDIV), .START_CYC(3)) uut (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_eng1_map(mp[0]), .i_eng2_map(mp[1]), .i_eng3_map(mp[2]),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_prog_mem_wr(mem_wr),
        .o_normal_mode(normal), .o_pwm_freeze(freeze), .o_engine_busy(busy),
        .o_engine_running(run), .o_pc1(pc1), .o_pc2(pc2), .o_pc3(pc3), .o_pump_gain_ctrl(pg));
    lpe_host_model host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_busy(busy),
        .o_wr(reg_wr), .o_rd(reg_rd), .o_addr(addr), .o_wdata(wdata));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    always @(posedge i_clk)
        if (mem_wr === 1'b1)
            mem_n++;

    function automatic logic [7:0] fld(input int e, input logic [1:0] c);
        return {6'h00, c} << (4 - 2 * e);
    endfunction
    function automatic logic [PC_W-1:0] pc_of(input int e);
        return (e == 0) ? pc1 : (e == 1) ? pc2 : pc3;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check("register", d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected few hundred cycles
    initial
    begin
        #200000;
        errors++;
        close_out();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h9670));
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        foreach (ra[i]) rchk(ra[i], 8'h00);
        host.wr(ADDR_ENABLE, 8'h3f);
        rchk(ADDR_ENABLE, 8'h00);
        host.wr(ADDR_PC1, 8'h05);
        rchk(ADDR_PC1, 8'h00);
        gain = 8'($urandom);
        host.wr(ADDR_GAIN, gain);
        rchk(ADDR_GAIN, gain);
        check("gain out", pg, gain);
        host.wr(ADDR_ENABLE, 8'h40);
        cyc(5);
        check("normal", {7'h0, normal}, 8'h01);
        $display("test standby done");
        // Step, once, free run and halt on each engine; engine 1 starts at the limit
        for (int e = 0; e < 3; e++)
        begin
            pc = (e == 0) ? PC_LIMIT : 7'($urandom % 96);
            host.wr(ADDR_PC1 + 8'(e), {1'b0, pc});
            rchk(ADDR_PC1 + 8'(e), {1'b0, pc});
            host.wr(ADDR_MODE, fld(e, MODE_RUN));
            host.wr(ADDR_ENABLE, 8'h40 | fld(e, EXEC_STEP));
            cyc(3 * TDIV);
            rchk(ADDR_ENABLE, 8'h40);
            p = (pc == PC_LIMIT) ? PC_ZERO : pc + PC_ONE;
            rchk(ADDR_PC1 + 8'(e), {1'b0, p});
            host.wr(ADDR_ENABLE, 8'h40 | fld(e, EXEC_ONCE));
            cyc(3 * TDIV);
            rchk(ADDR_ENABLE, 8'h40);
            rchk(ADDR_PC1 + 8'(e), {1'b0, p});
            host.wr(ADDR_ENABLE, 8'h40 | fld(e, EXEC_FREE));
            cyc(6 * TDIV);
            check("pc moved", {7'h0, pc_of(e) != p}, 8'h01);
            rchk(ADDR_PC1 + 8'(e), 8'h00);
            host.wr(ADDR_MODE, fld(e, MODE_HALT));
            cyc(2);
            check("running", {7'h0, run[e]}, 8'h00);
            host.wr(ADDR_ENABLE, 8'h40);
        end
        $display("test engines done");
        // Random mode patterns without load codes read back whole
        repeat (4)
        begin
            rv = 8'h00;
            for (int e = 0; e < 3; e++)
                rv |= fld(e, codes[$urandom % 3]);
            host.wr(ADDR_MODE, rv);
            rchk(ADDR_MODE, rv);
        end
        host.wr(ADDR_MODE, fld(0, MODE_RUN));
        host.wr(ADDR_MODE, fld(0, MODE_LOAD));
        rchk(ADDR_MODE, fld(0, MODE_RUN));
        // Engine 2 free runs, engine 1 loads from disabled
        host.wr(ADDR_MODE, fld(1, MODE_RUN));
        host.wr(ADDR_ENABLE, 8'h40 | fld(1, EXEC_FREE));
        host.wr(ADDR_MODE, fld(0, MODE_LOAD) | fld(1, MODE_RUN));
        cyc(1);
        check("busy", {5'h0, busy}, 8'h01);
        check("freeze", {7'h0, freeze}, 8'h01);
        check("pc1", {1'b0, pc1}, 8'h00);
        p = pc2;
        host.wr(ADDR_MEM_LO, 8'($urandom));
        host.load(ADDR_MEM_LO + 8'h01, 8'($urandom));
        cyc(2);
        check("mem writes", 8'(mem_n), 8'h01);
        check("pc2", {1'b0, pc2}, {1'b0, p});
        host.wr(ADDR_MODE, fld(1, MODE_RUN));
        host.wr(ADDR_MEM_LO, 8'($urandom));
        cyc(3 * TDIV);
        check("freeze", {7'h0, freeze}, 8'h00);
        check("mem writes", 8'(mem_n), 8'h01);
        check("pc2 moved", {7'h0, pc2 != p}, 8'h01);
        $display("test load done");
        // Random output maps; map registers ignore writes
        @(posedge i_clk);
        for (int e = 0; e < 3; e++)
            mp[e] <= 9'($urandom);
        cyc(2);
        for (int e = 0; e < 3; e++)
        begin
            host.wr(ADDR_MAP1_LO + 8'(2 * e), ~mp[e][7:0]);
            rchk(ADDR_MAP1_HI + 8'(2 * e), {7'h0, mp[e][8]});
            rchk(ADDR_MAP1_LO + 8'(2 * e), mp[e][7:0]);
        end
        $display("test maps done");
        close_out();
    end
endmodule // led_program_engine_control_tb
